// ==== hdl/trig_stat_defs.svh ====
`ifndef TRIG_STAT_DEFS_SVH
`define TRIG_STAT_DEFS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS   10
`define US_IN_NS        1000
// Cycles per microsecond, rounded up so a pulse is never short
`define CYC_PER_US      ((`US_IN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define IN_EN_RST       1'b0
`define IN_EDGE_RST     1'b0
`define OUT_EN_RST      1'b0
`define OUT_POL_RST     1'b0
`define OUTPUT_PULSE_LENGTH_RST      16'h0019
`define MASK_RST        16'h0000
`define LOCK_RST        1'b0

// ----------------------------------------------------------------
// Field encodings
// ----------------------------------------------------------------
`define TYPE_FALLING    1'b0
`define TYPE_RISING     1'b1
`define POS_ZERO        2'h0
`define POS_MIN         2'h1
`define POS_MAX         2'h2
`define ARG_CHAN_LSB    8

// ----------------------------------------------------------------
// Function codes and display
// ----------------------------------------------------------------
`define MODE_DISCRETE   4'h0
`define MODE_TRIANGLE   4'h1
`define MODE_RAYLEIGH   4'h2
`define MODE_TRIG_IN    4'h3
`define MODE_TORNADO    4'h4
`define MODE_LEGACY     4'h5
`define MODE_MODULATE   4'h6
`define MODE_MANUAL     4'h7
`define MODE_SETUP      4'h8
`define DISP_REMOTE     4'hf

// ----------------------------------------------------------------
// Settings readback bit positions
// ----------------------------------------------------------------
`define SET_IN_EN       0
`define SET_IN_TYPE     1
`define SET_OUT_EN      2
`define SET_OUT_TYPE    3
`define SET_LOCK        4

`endif

// ==== hdl/trig_stat_pkg.sv ====
package trig_stat_pkg;

  // ----------------------------------------------------------------
  // Remote command opcodes
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    CMD_NOP,
    CMD_IN_STATE,
    CMD_IN_TYPE,
    CMD_IN_COUNT_RD,
    CMD_IN_COUNT_CLR,
    CMD_OUT_STATE,
    CMD_OUT_TYPE,
    CMD_OUT_COUNT_RD,
    CMD_OUT_COUNT_CLR,
    CMD_OUT_WIDTH_WR,
    CMD_OUT_WIDTH_RD,
    CMD_OUT_POS_WR,
    CMD_OUT_POS_RD,
    CMD_DISP_LOCK,
    CMD_SETTINGS_RD,
    CMD_MODE_RD,
    CMD_QEVT_RD,
    CMD_QCOND_RD,
    CMD_QMASK_WR,
    CMD_QMASK_RD,
    CMD_OEVT_RD,
    CMD_OCOND_RD,
    CMD_OMASK_WR,
    CMD_OMASK_RD
  } cmd_e;

  // Output pulse timer states
  typedef enum logic {
    PT_IDLE,
    PT_ACTIVE
  } pulse_state_e;

endpackage

// ==== hdl/pulse_timer.sv ====
`include "trig_stat_defs.svh"

module pulse_timer
  import trig_stat_pkg::*;
#(
  parameter int W   = 16,
  parameter int DIV = `CYC_PER_US
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic         start,
  input  wire logic         abort,
  input  wire logic [W-1:0] widthUs,
  output logic              active,
  output logic              started
);

  localparam int PW = (DIV > 1) ? $clog2(DIV) : 1;

  pulse_state_e state_reg;   // Timer state
  logic [PW-1:0] pre_reg;    // Microsecond prescaler
  logic [W-1:0]  left_reg;   // Microseconds still to run

  // ----------------------------------------------------------------
  // Width timer
  // ----------------------------------------------------------------
  // Prescaler restarts at each pulse so the width is exact, not
  // jittered by a free-running tick
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg <= PT_IDLE;
      pre_reg   <= '0;
      left_reg  <= '0;
      started   <= 1'b0;
    end else begin
      started <= 1'b0;
      case (state_reg)
        PT_IDLE: begin
          // Zero width means no pulse at all
          if (start && !abort && widthUs != '0) begin
            state_reg <= PT_ACTIVE;
            pre_reg   <= '0;
            left_reg  <= widthUs;
            started   <= 1'b1;
          end
        end
        PT_ACTIVE: begin
          if (abort) begin
            state_reg <= PT_IDLE;
          end else if (pre_reg == PW'(DIV - 1)) begin
            pre_reg <= '0;
            if (left_reg == W'(1)) begin
              state_reg <= PT_IDLE;
            end else begin
              left_reg <= left_reg - W'(1);
            end
          end else begin
            pre_reg <= pre_reg + PW'(1);
          end
        end
        default: state_reg <= PT_IDLE;
      endcase
    end
  end

  assign active = (state_reg == PT_ACTIVE);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [31:0] lenCnt;    // Active cycles so far
  logic [W-1:0] widLat;   // Width latched at start
  logic         aborted;  // Pulse cut short

  always_ff @(posedge core_clk) begin
    if (rst) begin
      lenCnt  <= '0;
      widLat  <= '0;
      aborted <= 1'b0;
    end else if (started) begin
      lenCnt  <= 32'd1;
      widLat  <= left_reg;
      aborted <= 1'b0;
    end else if (active) begin
      lenCnt  <= lenCnt + 32'd1;
      aborted <= aborted | abort;
    end
  end

  property p_pulse_len;
    @(posedge core_clk) disable iff (rst)
    $fell(active) && !$past(abort) && !aborted |->
      lenCnt == 32'(widLat) * 32'(DIV);
  endproperty
  a_pulse_len: assert property (p_pulse_len)
    else $error("Output pulse width wrong");

endmodule

// ==== hdl/trigger_and_status_control.sv ====
// Function
// - Trigger input enable, off after reset
// - Input edge selectable, falling by default
// - Input event counter, readable and clearable
// - Trigger output enable, off by default
// - Output pulse polarity selectable, falling default
// - Output pulse counter, readable and clearable
// - Output pulse width 0-65535 us, 25 default
// - Fire at channel max or min/zero
// - Display lock shows remote indication
// - Report active function as numeric code
// - Suspect event register cleared on read
// - Both condition registers readable live
// - Suspect event enable mask, 16 bits
// - Operation event enable mask, 16 bits
// - Operation event register latches, readable
`include "trig_stat_defs.svh"

module trigger_and_status_control
  import trig_stat_pkg::*;
#(
  parameter int NCH   = 4,   // Waveform channels
  parameter int CNT_W = 32,  // Counter width
  parameter int PW_W  = 16   // Pulse width field
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             trigInPin,
  output logic                  trigOutPin,
  input  wire logic             cmdValid,
  input  wire cmd_e             cmdOp,
  input  wire logic [15:0]      cmdArg,
  output logic                  rspValid,
  output logic [CNT_W-1:0]      rspData,
  input  wire logic [NCH-1:0]   chanPeak,
  input  wire logic [NCH-1:0]   chanTrough,
  input  wire logic [3:0]       activeMode,
  input  wire logic [15:0]      suspectCond,
  input  wire logic [15:0]      operCond,
  output logic [3:0]            modeCode,
  output logic [3:0]            displayShow,
  output logic                  trigInEvent
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam int CH_W = (NCH > 1) ? $clog2(NCH) : 1;

  logic             inEnable_reg;     // Input trigger armed
  logic             inType_reg;       // 1 rising, 0 falling
  logic             outEnable_reg;    // Output trigger armed
  logic             outType_reg;      // 1 high-going, 0 low-going
  logic [PW_W-1:0]  pulseWidth_reg;   // Output width in us
  logic [1:0]       outPos_reg [NCH]; // Per channel fire point
  logic             lock_reg;         // Display lock
  logic [CNT_W-1:0] inCount_reg;      // Accepted input edges
  logic [CNT_W-1:0] outCount_reg;     // Emitted output pulses
  logic [15:0]      qEvt_reg;         // questionable_event_latch
  logic [15:0]      qMask_reg;        // questionable_event_mask
  logic [15:0]      oEvt_reg;         // Operation event latch
  logic [15:0]      oMask_reg;        // operation_event_mask
  logic [15:0]      qCondQ_reg;       // Last suspect conditions
  logic [15:0]      oCondQ_reg;       // Last operation conditions
  logic [2:0]       inSync_reg;       // Pin synchroniser and history

  logic             inRise;           // Rising edge seen
  logic             inFall;           // Falling edge seen
  logic             inAccept;         // Edge counted
  logic             fireReq;          // Channel reached fire point
  logic             timerActive;      // Pulse in progress
  logic             timerStarted;     // Pulse began this cycle
  logic [15:0]      qSet;             // Suspect bits to set
  logic [15:0]      oSet;             // Operation bits to set
  logic [CH_W-1:0]  argChan;          // Channel named by argument

  // Decoded command strobes
  function automatic logic isCmd(input cmd_e op);
    return cmdValid && (cmdOp == op);
  endfunction

  // True when a channel's setting asks for the maximum point
  function automatic logic atMax(input logic [1:0] pos);
    return pos == `POS_MAX;
  endfunction

  assign argChan = cmdArg[`ARG_CHAN_LSB +: CH_W];

  // ----------------------------------------------------------------
  // Trigger input
  // ----------------------------------------------------------------
  // Two stages before any logic reads the pin; the third is history
  always_ff @(posedge core_clk) begin
    if (rst) begin
      inSync_reg <= 3'h0;
    end else begin
      inSync_reg <= {inSync_reg[1:0], trigInPin};
    end
  end

  // Edge taken from the second and third stages only
  assign inRise   = inSync_reg[1] && !inSync_reg[2];
  assign inFall   = !inSync_reg[1] && inSync_reg[2];
  assign inAccept = inEnable_reg &&
                    (inType_reg ? inRise : inFall);

  // Event pulse, one cycle per accepted edge
  always_ff @(posedge core_clk) begin
    if (rst) begin
      trigInEvent <= 1'b0;
    end else begin
      trigInEvent <= inAccept;
    end
  end

  // Input counter; an edge in the clear cycle still counts
  always_ff @(posedge core_clk) begin
    if (rst) begin
      inCount_reg <= '0;
    end else if (isCmd(CMD_IN_COUNT_CLR)) begin
      inCount_reg <= CNT_W'(inAccept);
    end else if (inAccept) begin
      inCount_reg <= inCount_reg + CNT_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Settings written by command
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      inEnable_reg   <= `IN_EN_RST;
      inType_reg     <= `IN_EDGE_RST;
      outEnable_reg  <= `OUT_EN_RST;
      outType_reg    <= `OUT_POL_RST;
      pulseWidth_reg <= `OUTPUT_PULSE_LENGTH_RST;
      lock_reg       <= `LOCK_RST;
    end else if (cmdValid) begin
      case (cmdOp)
        CMD_IN_STATE:     inEnable_reg   <= cmdArg[0];
        CMD_IN_TYPE:      inType_reg     <= cmdArg[0];
        CMD_OUT_STATE:    outEnable_reg  <= cmdArg[0];
        CMD_OUT_TYPE:     outType_reg    <= cmdArg[0];
        CMD_OUT_WIDTH_WR: pulseWidth_reg <= cmdArg;
        CMD_DISP_LOCK:    lock_reg       <= cmdArg[0];
        default:          ;
      endcase
    end
  end

  // Per-channel fire point; an unused code falls back to zero
  // Whole channel field is compared, so a channel past NCH cannot alias
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < NCH; i++) begin
        outPos_reg[i] <= `POS_ZERO;
      end
    end else if (isCmd(CMD_OUT_POS_WR) && cmdArg[15:`ARG_CHAN_LSB] < 8'(NCH)) begin
      outPos_reg[argChan] <= atMax(cmdArg[1:0]) ? `POS_MAX :
                             (cmdArg[1:0] == `POS_MIN) ? `POS_MIN : `POS_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // Trigger output
  // ----------------------------------------------------------------
  // Min and zero both fire on the trough
  always_comb begin
    fireReq = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      fireReq = fireReq |
                (atMax(outPos_reg[i]) ? chanPeak[i] : chanTrough[i]);
    end
  end

  // Fire points that land inside a running pulse are dropped
  pulse_timer #(
    .W   (PW_W),
    .DIV (`CYC_PER_US)
  ) u_timer (
    .core_clk (core_clk),
    .rst      (rst),
    .start    (fireReq && outEnable_reg),
    .abort    (!outEnable_reg),
    .widthUs  (pulseWidth_reg),
    .active   (timerActive),
    .started  (timerStarted)
  );

  // Pin idles at the opposite level of the pulse
  always_ff @(posedge core_clk) begin
    if (rst) begin
      trigOutPin <= ~`OUT_POL_RST;
    end else begin
      trigOutPin <= timerActive ^ ~outType_reg;
    end
  end

  // Output counter, pulse in the clear cycle still counts
  always_ff @(posedge core_clk) begin
    if (rst) begin
      outCount_reg <= '0;
    end else if (isCmd(CMD_OUT_COUNT_CLR)) begin
      outCount_reg <= CNT_W'(timerStarted);
    end else if (timerStarted) begin
      outCount_reg <= outCount_reg + CNT_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // Mode and display
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      modeCode    <= `MODE_DISCRETE;
      displayShow <= `MODE_DISCRETE;
    end else begin
      modeCode    <= activeMode;
      displayShow <= lock_reg ? `DISP_REMOTE : activeMode;
    end
  end

  // ----------------------------------------------------------------
  // Status groups
  // ----------------------------------------------------------------
  // Only enabled bits rising from inactive may latch
  assign qSet = suspectCond & ~qCondQ_reg & qMask_reg;
  assign oSet = operCond & ~oCondQ_reg & oMask_reg;

  // Condition history for rise detection
  always_ff @(posedge core_clk) begin
    if (rst) begin
      qCondQ_reg <= 16'h0000;
      oCondQ_reg <= 16'h0000;
    end else begin
      qCondQ_reg <= suspectCond;
      oCondQ_reg <= operCond;
    end
  end

  // Latches: a set arriving with the clearing read survives
  always_ff @(posedge core_clk) begin
    if (rst) begin
      qEvt_reg <= 16'h0000;
      oEvt_reg <= 16'h0000;
    end else begin
      qEvt_reg <= (isCmd(CMD_QEVT_RD) ? 16'h0000 : qEvt_reg) | qSet;
      oEvt_reg <= (isCmd(CMD_OEVT_RD) ? 16'h0000 : oEvt_reg) | oSet;
    end
  end

  // Enable masks
  always_ff @(posedge core_clk) begin
    if (rst) begin
      qMask_reg <= `MASK_RST;
      oMask_reg <= `MASK_RST;
    end else begin
      if (isCmd(CMD_QMASK_WR)) begin
        qMask_reg <= cmdArg;
      end
      if (isCmd(CMD_OMASK_WR)) begin
        oMask_reg <= cmdArg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Command answers
  // ----------------------------------------------------------------
  // Every command is answered one cycle later; writes answer zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rspValid <= 1'b0;
      rspData  <= '0;
    end else begin
      rspValid <= cmdValid;
      rspData  <= '0;
      if (cmdValid) begin
        case (cmdOp)
          CMD_IN_COUNT_RD:  rspData <= inCount_reg;
          CMD_OUT_COUNT_RD: rspData <= outCount_reg;
          CMD_OUT_WIDTH_RD: rspData <= CNT_W'(pulseWidth_reg);
          CMD_OUT_POS_RD:   rspData <= CNT_W'(outPos_reg[argChan]);
          CMD_SETTINGS_RD: begin
            rspData[`SET_IN_EN]    <= inEnable_reg;
            rspData[`SET_IN_TYPE]  <= inType_reg;
            rspData[`SET_OUT_EN]   <= outEnable_reg;
            rspData[`SET_OUT_TYPE] <= outType_reg;
            rspData[`SET_LOCK]     <= lock_reg;
          end
          CMD_MODE_RD:      rspData <= CNT_W'(modeCode);
          CMD_QEVT_RD:      rspData <= CNT_W'(qEvt_reg);
          CMD_QCOND_RD:     rspData <= CNT_W'(suspectCond);
          CMD_QMASK_RD:     rspData <= CNT_W'(qMask_reg);
          CMD_OEVT_RD:      rspData <= CNT_W'(oEvt_reg);
          CMD_OCOND_RD:     rspData <= CNT_W'(operCond);
          CMD_OMASK_RD:     rspData <= CNT_W'(oMask_reg);
          default:          rspData <= '0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_in_gate;
    !inEnable_reg |=> !trigInEvent;
  endproperty
  a_in_gate: assert property (p_in_gate)
    else $error("Input event while disabled");

  property p_in_edge;
    trigInEvent |-> $past(inType_reg ? inRise : inFall);
  endproperty
  a_in_edge: assert property (p_in_edge)
    else $error("Input event on wrong edge");

  property p_in_count;
    trigInEvent && !$past(isCmd(CMD_IN_COUNT_CLR)) |->
      inCount_reg == $past(inCount_reg) + CNT_W'(1);
  endproperty
  a_in_count: assert property (p_in_count)
    else $error("Input counter missed an event");

  property p_out_idle;
    !outEnable_reg [*3] |-> trigOutPin == ~$past(outType_reg);
  endproperty
  a_out_idle: assert property (p_out_idle)
    else $error("Output pulse while disabled");

  property p_out_pol;
    timerActive && $stable(outType_reg) |=> trigOutPin == $past(outType_reg);
  endproperty
  a_out_pol: assert property (p_out_pol)
    else $error("Output pulse has wrong level");

  property p_out_count;
    timerStarted && !isCmd(CMD_OUT_COUNT_CLR) |=>
      outCount_reg == $past(outCount_reg) + CNT_W'(1);
  endproperty
  a_out_count: assert property (p_out_count)
    else $error("Output counter missed a pulse");

  property p_lock;
    lock_reg |=> displayShow == `DISP_REMOTE;
  endproperty
  a_lock: assert property (p_lock)
    else $error("Lock not shown on display");

  property p_qevt_clear;
    isCmd(CMD_QEVT_RD) |=> rspValid && rspData == CNT_W'($past(qEvt_reg))
      && qEvt_reg == $past(qSet);
  endproperty
  a_qevt_clear: assert property (p_qevt_clear)
    else $error("Suspect event read did not clear");

  property p_oevt_set;
    $rose(operCond[0]) && oMask_reg[0] ##1 !isCmd(CMD_OEVT_RD) |=> oEvt_reg[0];
  endproperty
  a_oevt_set: assert property (p_oevt_set)
    else $error("Operation event not latched");

  property p_in_once;
    trigInEvent |=> !trigInEvent;
  endproperty
  a_in_once: assert property (p_in_once)
    else $error("One edge gave two events");

endmodule

// ==== bench/trig_equipment.sv ====
// External equipment: sends edges, times output pulses
module trig_equipment (
  input  wire logic core_clk,
  input  wire logic trigOutPin,
  input  wire logic idleLvl,
  output logic      trigInPin,
  output int        lastWidth
);
  timeunit 1ns;
  timeprecision 1ps;

  int run;  // Active cycles of the pulse in progress

  // Pin idles high, as a pulled-up trigger line would
  initial begin
    trigInPin = 1'b1;
  end

  // Width of each output pulse, counted in clock cycles
  always @(posedge core_clk) begin
    if (trigOutPin !== idleLvl) begin
      run <= run + 1;
    end else if (run != 0) begin
      lastWidth <= run;
      run <= 0;
    end
  end

  // Low-going pulse held 3 cycles: one falling, one rising edge
  task automatic pulse_low();
    @(negedge core_clk);
    trigInPin = 1'b0;
    repeat (3) @(negedge core_clk);
    trigInPin = 1'b1;
    repeat (6) @(negedge core_clk);
  endtask
endmodule

// ==== bench/trigger_and_status_control_tb_top.sv ====
module trigger_and_status_control_tb_top
  import trig_stat_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        core_clk, rst, trigInPin, trigOutPin, cmdValid, rspValid, trigInEvent, idleLvl;
  cmd_e        cmdOp;
  logic [15:0] cmdArg, suspectCond, operCond, m, mi, v;
  logic [31:0] rspData;
  logic [3:0]  chanPeak, chanTrough, activeMode, modeCode, displayShow;
  int          err_count, check_count, evCount, cyc, lastWidth;
  logic [31:0] expQ[$];  // Expected answers, oldest first
  string       nameQ[$];

  trigger_and_status_control dut (.core_clk(core_clk), .rst(rst), .trigInPin(trigInPin),
    .trigOutPin(trigOutPin), .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdArg(cmdArg),
    .rspValid(rspValid), .rspData(rspData), .chanPeak(chanPeak), .chanTrough(chanTrough),
    .activeMode(activeMode), .suspectCond(suspectCond), .operCond(operCond),
    .modeCode(modeCode), .displayShow(displayShow), .trigInEvent(trigInEvent));

  trig_equipment pe (.core_clk(core_clk), .trigOutPin(trigOutPin), .idleLvl(idleLvl),
    .trigInPin(trigInPin), .lastWidth(lastWidth));

  // 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Hang guard, far above the 1250 or so cycles the run needs
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(string n, logic [31:0] e, logic [31:0] s);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  // One command; answer is judged later by the monitor
  task automatic cmd(cmd_e op, logic [15:0] arg, logic [31:0] e);
    @(negedge core_clk);
    cmdValid = 1'b1;
    cmdOp = op;
    cmdArg = arg;
    expQ.push_back(e);
    nameQ.push_back(op.name());
    @(negedge core_clk);
    cmdValid = 1'b0;
  endtask

  // One-cycle fire point, then room for a full pulse of width 2
  task automatic fire(logic [3:0] p, logic [3:0] t);
    @(negedge core_clk);
    chanPeak = p;
    chanTrough = t;
    @(negedge core_clk);
    chanPeak = 4'h0;
    chanTrough = 4'h0;
    repeat (220) @(negedge core_clk);
  endtask

  task automatic report_and_stop();
    if (expQ.size() != 0) err_count++;
    if (err_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Monitor: answers and input events, sampled mid-cycle where settled
  always @(negedge core_clk) begin
    if (rspValid === 1'b1) begin
      if (expQ.size() == 0) check("unexpected answer", 32'h0, 32'h1);
      else check(nameQ.pop_front(), expQ.pop_front(), rspData);
    end
    if (trigInEvent === 1'b1) evCount++;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'hfcb8));
    {rst, idleLvl} = 2'b11;
    {cmdValid, chanPeak, chanTrough, activeMode, suspectCond, operCond} = '0;
    cmdOp = CMD_NOP;
    cmdArg = 16'h0000;
    repeat (5) @(negedge core_clk);
    rst = 1'b0;
    check("trigOutPin", 32'h1, {31'h0, trigOutPin});
    cmd(CMD_SETTINGS_RD, 16'h0000, 32'h0);
    cmd(CMD_OUT_WIDTH_RD, 16'h0000, 32'h19);
    cmd(CMD_OUT_POS_RD, 16'h0300, 32'h0);
    // Input edges: ignored while off, then falling only, then rising only
    pe.pulse_low();
    cmd(CMD_IN_COUNT_RD, 16'h0000, 32'h0);
    cmd(CMD_IN_STATE, 16'h0001, 32'h0);
    pe.pulse_low();
    cmd(CMD_IN_COUNT_RD, 16'h0000, 32'h1);
    cmd(CMD_IN_TYPE, 16'h0001, 32'h0);
    pe.pulse_low();
    cmd(CMD_IN_COUNT_RD, 16'h0000, 32'h2);
    check("trigInEvent pulses", 32'h2, evCount);
    cmd(CMD_IN_COUNT_CLR, 16'h0000, 32'h0);
    cmd(CMD_IN_COUNT_RD, 16'h0000, 32'h0);
    // Output pulses: width, polarity, fire position, count, enable
    cmd(CMD_OUT_WIDTH_WR, 16'h0001, 32'h0);
    cmd(CMD_OUT_STATE, 16'h0001, 32'h0);
    fire(4'h0, 4'h1);
    check("pulse cycles", 32'd100, lastWidth);
    cmd(CMD_OUT_TYPE, 16'h0001, 32'h0);
    idleLvl = 1'b0;
    cmd(CMD_OUT_WIDTH_WR, 16'h0002, 32'h0);
    cmd(CMD_OUT_POS_WR, 16'h0102, 32'h0);
    cmd(CMD_OUT_POS_RD, 16'h0100, 32'h2);
    // Channel 2 at min; a write to channel 4 must be ignored
    cmd(CMD_OUT_POS_WR, 16'h0201, 32'h0);
    cmd(CMD_OUT_POS_WR, 16'h0402, 32'h0);
    cmd(CMD_OUT_POS_RD, 16'h0200, 32'h1);
    cmd(CMD_OUT_POS_RD, 16'h0000, 32'h0);
    fire(4'h0, 4'h2);
    fire(4'h0, 4'h4);
    fire(4'h2, 4'h0);
    check("pulse cycles", 32'd200, lastWidth);
    check("trigOutPin", 32'h0, {31'h0, trigOutPin});
    cmd(CMD_OUT_COUNT_RD, 16'h0000, 32'h3);
    cmd(CMD_OUT_COUNT_CLR, 16'h0000, 32'h0);
    cmd(CMD_OUT_COUNT_RD, 16'h0000, 32'h0);
    cmd(CMD_OUT_STATE, 16'h0000, 32'h0);
    fire(4'h2, 4'h0);
    cmd(CMD_OUT_COUNT_RD, 16'h0000, 32'h0);
    // Every function code, then the locked display
    for (int k = 0; k < 9; k++) begin
      activeMode = k[3:0];
      cmd(CMD_MODE_RD, 16'h0000, k);
      check("modeCode", k, {28'h0, modeCode});
      check("displayShow", k, {28'h0, displayShow});
    end
    cmd(CMD_DISP_LOCK, 16'h0001, 32'h0);
    // Display register follows the lock one cycle later
    @(negedge core_clk);
    check("displayShow", 32'hf, {28'h0, displayShow});
    cmd(CMD_SETTINGS_RD, 16'h0000, 32'h1b);
    // Status: random masks and conditions
    // Bit 0 kept out of the suspect mask and set, so it latches on the operation side
    m = 16'($urandom()) & 16'hfffe;
    mi = ~m;
    v = 16'($urandom()) | 16'h0001;
    cmd(CMD_QMASK_WR, m, 32'h0);
    cmd(CMD_QMASK_RD, 16'h0000, {16'h0, m});
    cmd(CMD_OMASK_WR, mi, 32'h0);
    cmd(CMD_OMASK_RD, 16'h0000, {16'h0, mi});
    suspectCond = v;
    operCond = v;
    cmd(CMD_QCOND_RD, 16'h0000, {16'h0, v});
    cmd(CMD_OCOND_RD, 16'h0000, {16'h0, v});
    cmd(CMD_QEVT_RD, 16'h0000, {16'h0, v & m});
    cmd(CMD_QEVT_RD, 16'h0000, 32'h0);
    cmd(CMD_OEVT_RD, 16'h0000, {16'h0, v & mi});
    repeat (3) @(negedge core_clk);
    report_and_stop();
  end
endmodule
